// ===== drsc_pkg.sv
// constants and types for the dual rheostat serial command unit
// assumes a 10 MHz system clock and a slow serial link sampled by it
// Operation
// - decode wiper code into one of 1024 taps
// - code zero selects B tap, one tap per LSB
// - command B writes data to addressed wiper
// - command E increments addressed wiper
// - command 2 saves wiper to its backup slot
// - write protect low blocks nonvolatile changes
// - reload wipers at power-on, recall strobe, restore
// - command 1 restores addressed wiper from backup
// - command 8 restores both wipers
// - command 0 changes nothing, returns to idle power
// - command C doubles addressed wiper by left shift
// - left shift saturates at full scale
// - command 3 writes 16-bit data to user slot
// - command 9 reads slot out next frame
// - command A reads wiper out next frame
// - frame is 24 bits, MSB first, cmd addr data
// - command executes when chip select rises
// - serial output released while chip select high
// - serial output passes shifted data for chaining
package drsc_pkg;
	localparam int frame_bits = 24;
	localparam int wiper_bits = 10;
	localparam int tap_count = 1024;
	localparam int slot_bits = 16;
	localparam int slot_count = 16;
	localparam int slot_addr_bits = 4;
	localparam logic [3:0] cmd_nop = 4'h0;
	localparam logic [3:0] cmd_restore = 4'h1;
	localparam logic [3:0] cmd_save = 4'h2;
	localparam logic [3:0] cmd_user_write = 4'h3;
	localparam logic [3:0] cmd_restore_all = 4'h8;
	localparam logic [3:0] cmd_slot_read = 4'h9;
	localparam logic [3:0] cmd_wiper_read = 4'ha;
	localparam logic [3:0] cmd_wiper_write = 4'hb;
	localparam logic [3:0] cmd_shift_left = 4'hc;
	localparam logic [3:0] cmd_increment = 4'he;
	localparam logic [9:0] wiper_full = 10'h3ff;
	localparam logic [9:0] wiper_reset = 10'h000;
	localparam logic [15:0] slot_reset = 16'h0000;
	typedef struct packed {
		logic [3:0] cmd;
		logic [3:0] addr;
		logic [15:0] data;
	} drsc_frame_type;
	typedef enum logic [2:0] {
		drsc_boot = 3'b001,
		drsc_idle = 3'b010,
		drsc_restore = 3'b100
	} drsc_state_type;
endpackage

// ===== drsc_nv_mem.sv
// nonvolatile slot array of the rheostat unit
// assumes one write and one read per cycle; read data registered
`timescale 1ns/100ps
`default_nettype none
module drsc_nv_mem #(
	parameter int width = 16,
	parameter int depth = 16,
	parameter int abits = 4
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic we,
	input wire logic [abits-1:0] waddr,
	input wire logic [width-1:0] wdata,
	input wire logic [abits-1:0] raddr,
	output logic [width-1:0] rdata
);
	logic [width-1:0] mem [depth];
	// blank parts read as all zeros, so the power-on reload never loads unknowns
	initial begin
		for (int i = 0; i < depth; i++) begin
			mem[i] = '0;
		end
	end
	always @(posedge clk) begin
		if (ce) begin
			if (we) begin
				mem[waddr] <= wdata;
			end
			rdata <= mem[raddr];
		end
	end
endmodule
`default_nettype wire

// ===== drsc_unit.sv
// serial command unit of the dual rheostat with nonvolatile backup
// assumes sclk, sdi, cs_n, wp_n, recall_strobe_n arrive asynchronously
`timescale 1ns/100ps
`default_nettype none
module drsc_unit (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic cs_n,
	input wire logic wp_n,
	input wire logic recall_strobe_n,
	output logic sdo_o,
	output logic sdo_oe,
	output logic [1023:0] tap_sel_ch1,
	output logic [1023:0] tap_sel_ch2,
	output logic read_power
);
	// synchronisers
	logic [4:0] s1;
	logic [4:0] s2;
	logic [4:0] next_s1;
	logic [4:0] next_s2;
	always_comb begin
		next_s1 = {sclk, sdi, cs_n, wp_n, recall_strobe_n};
		next_s2 = s1;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1 <= 5'h1f;
			s2 <= 5'h1f;
		end else if (ce) begin
			s1 <= next_s1;
			s2 <= next_s2;
		end
	end
	logic sclk_s, sdi_s, cs_s, wp_s, rcl_s;
	assign {sclk_s, sdi_s, cs_s, wp_s, rcl_s} = s2;

	logic sclk_d, cs_d, rcl_d;
	logic [23:0] shreg;
	logic [23:0] out_word;
	logic [9:0] wiper_register_ch1;
	logic [9:0] wiper_register_ch2;
	logic sdo_bit;
	logic drive;
	logic rp;
	drsc_pkg::drsc_state_type state;
	logic [1:0] boot_step;
	logic [9:0] tap_code_1, tap_code_2;

	logic next_sclk_d, next_cs_d, next_rcl_d, next_sdo_bit, next_drive, next_rp;
	logic [23:0] next_shreg, next_out_word;
	logic [9:0] next_w1, next_w2;
	drsc_pkg::drsc_state_type next_state;
	logic [1:0] next_boot_step;
	// bit 0 reloads channel 1, bit 1 reloads channel 2
	logic [1:0] load_en, next_load_en;

	logic nv_we;
	logic [3:0] nv_waddr;
	logic [15:0] nv_wdata;
	logic [3:0] nv_raddr;
	logic [15:0] nv_rdata;

	drsc_nv_mem #(
		.width(drsc_pkg::slot_bits),
		.depth(drsc_pkg::slot_count),
		.abits(drsc_pkg::slot_addr_bits)
	) u_nv_store (
		.clk(clk),
		.ce(ce),
		.we(nv_we),
		.waddr(nv_waddr),
		.wdata(nv_wdata),
		.raddr(nv_raddr),
		.rdata(nv_rdata)
	);

	drsc_pkg::drsc_frame_type fr;
	logic rise_sclk, fall_sclk, cs_rise, cs_fall, rcl_fall;
	logic [10:0] dbl;
	always_comb begin
		fr = drsc_pkg::drsc_frame_type'(shreg);
		rise_sclk = sclk_s && !sclk_d && !cs_s;
		fall_sclk = !sclk_s && sclk_d && !cs_s;
		cs_rise = cs_s && !cs_d;
		cs_fall = !cs_s && cs_d;
		rcl_fall = !rcl_s && rcl_d;
		dbl = {(fr.addr[0] ? wiper_register_ch2 : wiper_register_ch1), 1'b0};
		next_sclk_d = sclk_s;
		next_cs_d = cs_s;
		next_rcl_d = rcl_s;
		next_shreg = shreg;
		next_out_word = out_word;
		next_w1 = wiper_register_ch1;
		next_w2 = wiper_register_ch2;
		next_sdo_bit = sdo_bit;
		next_drive = !cs_s;
		next_rp = rp;
		next_state = state;
		next_boot_step = boot_step;
		next_load_en = load_en;
		nv_we = 1'b0;
		nv_waddr = fr.addr;
		nv_wdata = fr.data;
		nv_raddr = fr.addr;
		if (cs_fall) begin
			next_sdo_bit = out_word[23];
		end
		if (rise_sclk) begin
			next_shreg = {shreg[22:0], sdi_s};
			next_out_word = {out_word[22:0], 1'b0};
		end
		if (fall_sclk) begin
			next_sdo_bit = out_word[23];
		end
		unique case (state)
			drsc_pkg::drsc_boot: begin
				// power-on reload, channel 1 then channel 2
				nv_raddr = {3'h0, boot_step[0]};
				next_boot_step = boot_step + 2'h1;
				next_cs_d = cs_d;
				if (boot_step == 2'h1 && load_en[0]) begin
					next_w1 = nv_rdata[9:0];
				end
				if (boot_step == 2'h2) begin
					if (load_en[1]) begin
						next_w2 = nv_rdata[9:0];
					end
					next_state = drsc_pkg::drsc_idle;
				end
			end
			drsc_pkg::drsc_restore: begin
				nv_raddr = {3'h0, boot_step[0]};
				next_boot_step = boot_step + 2'h1;
				// a frame ending during the reload is taken once it is done
				next_cs_d = cs_d;
				if (boot_step == 2'h1 && load_en[0]) begin
					next_w1 = nv_rdata[9:0];
				end
				if (boot_step == 2'h2) begin
					if (load_en[1]) begin
						next_w2 = nv_rdata[9:0];
					end
					next_state = drsc_pkg::drsc_idle;
				end
			end
			drsc_pkg::drsc_idle: begin
				if (rcl_fall) begin
					next_boot_step = 2'h0;
					next_load_en = 2'b11;
					next_cs_d = cs_d;
					next_state = drsc_pkg::drsc_restore;
				end else if (cs_rise) begin
					next_out_word = shreg;
					unique case (fr.cmd)
						drsc_pkg::cmd_nop: next_rp = 1'b0;
						drsc_pkg::cmd_restore: begin
							next_rp = 1'b1;
							next_boot_step = 2'h0;
							next_load_en = fr.addr[0] ? 2'b10 : 2'b01;
							next_state = drsc_pkg::drsc_restore;
						end
						drsc_pkg::cmd_restore_all: begin
							next_rp = 1'b1;
							next_boot_step = 2'h0;
							next_load_en = 2'b11;
							next_state = drsc_pkg::drsc_restore;
						end
						drsc_pkg::cmd_save: begin
							nv_waddr = {3'h0, fr.addr[0]};
							nv_wdata = {6'h00, dbl[10:1]};
							nv_we = wp_s;
						end
						drsc_pkg::cmd_user_write: begin
							nv_we = wp_s && fr.addr >= 4'h2 && fr.addr <= 4'he;
						end
						drsc_pkg::cmd_wiper_write: begin
							if (fr.addr[0]) next_w2 = fr.data[9:0];
							else next_w1 = fr.data[9:0];
						end
						drsc_pkg::cmd_increment: begin
							if (fr.addr[0]) next_w2 = wiper_register_ch2 + 10'h001;
							else next_w1 = wiper_register_ch1 + 10'h001;
						end
						drsc_pkg::cmd_shift_left: begin
							if (fr.addr[0]) next_w2 = dbl[10] ? drsc_pkg::wiper_full : dbl[9:0];
							else next_w1 = dbl[10] ? drsc_pkg::wiper_full : dbl[9:0];
						end
						drsc_pkg::cmd_wiper_read: begin
							next_rp = 1'b1;
							next_out_word = {fr.cmd, fr.addr, 6'h00, dbl[10:1]};
						end
						drsc_pkg::cmd_slot_read: begin
							next_rp = 1'b1;
						end
						default: begin
						end
					endcase
				end else if (cs_d && s2[2] && cs_s && rp && nv_raddr == out_word[19:16]
					&& out_word[23:20] == drsc_pkg::cmd_slot_read) begin
					next_out_word = {out_word[23:16], nv_rdata};
				end
			end
			default: next_state = drsc_pkg::drsc_idle;
		endcase
		// slot read: present address of the prepared frame to the memory
		if (state == drsc_pkg::drsc_idle && !cs_rise && cs_s) begin
			nv_raddr = out_word[19:16];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclk_d <= 1'b0;
			cs_d <= 1'b1;
			rcl_d <= 1'b1;
			shreg <= 24'h000000;
			out_word <= 24'h000000;
			wiper_register_ch1 <= drsc_pkg::wiper_reset;
			wiper_register_ch2 <= drsc_pkg::wiper_reset;
			sdo_bit <= 1'b1;
			drive <= 1'b0;
			rp <= 1'b0;
			state <= drsc_pkg::drsc_boot;
			boot_step <= 2'h0;
			load_en <= 2'b11;
		end else if (ce) begin
			sclk_d <= next_sclk_d;
			cs_d <= next_cs_d;
			rcl_d <= next_rcl_d;
			shreg <= next_shreg;
			out_word <= next_out_word;
			wiper_register_ch1 <= next_w1;
			wiper_register_ch2 <= next_w2;
			sdo_bit <= next_sdo_bit;
			drive <= next_drive;
			rp <= next_rp;
			state <= next_state;
			boot_step <= next_boot_step;
			load_en <= next_load_en;
		end
	end

	// open drain: pull low for a zero, release otherwise
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sdo_o <= 1'b0;
			sdo_oe <= 1'b0;
			read_power <= 1'b0;
		end else if (ce) begin
			sdo_o <= 1'b0;
			sdo_oe <= drive && !cs_s && !sdo_bit;
			read_power <= rp;
		end
	end

	// tap decode, one-hot per channel
	assign tap_code_1 = wiper_register_ch1;
	assign tap_code_2 = wiper_register_ch2;
	genvar t;
	generate
		for (t = 0; t < drsc_pkg::tap_count; t++) begin : g_tap
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					tap_sel_ch1[t] <= (t == 0);
					tap_sel_ch2[t] <= (t == 0);
				end else if (ce) begin
					tap_sel_ch1[t] <= (tap_code_1 == 10'(t));
					tap_sel_ch2[t] <= (tap_code_2 == 10'(t));
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ===== drsc_unit_properties.sv
// pin-level assertions for the rheostat command unit
// assumes it is bound to drsc_unit with ce held high
`timescale 1ns/100ps
`default_nettype none
module drsc_unit_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic cs_n,
	input wire logic wp_n,
	input wire logic recall_strobe_n,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	input wire logic [1023:0] tap_sel_ch1,
	input wire logic [1023:0] tap_sel_ch2,
	input wire logic read_power
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	onehot_ch1_a: assert property ($onehot(tap_sel_ch1))
		else $error("ch1 tap not one-hot");
	onehot_ch2_a: assert property ($onehot(tap_sel_ch2))
		else $error("ch2 tap not one-hot");
	reset_tap_a: assert property (disable iff (1'b0)
		!rst_n && ce |=> tap_sel_ch1 == 1024'h1 && tap_sel_ch2 == 1024'h1)
		else $error("reset tap not at B end");
	drain_low_a: assert property (sdo_oe |-> !sdo_o)
		else $error("sdo driven high");
	sdo_release_a: assert property (cs_n [*5] |-> !sdo_oe)
		else $error("sdo held while deselected");
	sdo_hold_a: assert property ((!cs_n && sclk) [*3] |-> $stable(sdo_oe))
		else $error("sdo moved while sclk high");
	tap_exec_a: assert property ($changed(tap_sel_ch1) || $changed(tap_sel_ch2) |-> cs_n)
		else $error("tap moved inside a frame");
	power_exec_a: assert property ($changed(read_power) |-> cs_n)
		else $error("power state moved inside a frame");
endmodule
bind drsc_unit drsc_unit_properties u_props (.clk(clk), .rst_n(rst_n), .ce(ce), .sclk(sclk),
	.sdi(sdi), .cs_n(cs_n), .wp_n(wp_n), .recall_strobe_n(recall_strobe_n), .sdo_o(sdo_o),
	.sdo_oe(sdo_oe), .tap_sel_ch1(tap_sel_ch1), .tap_sel_ch2(tap_sel_ch2),
	.read_power(read_power));
`default_nettype wire

// ===== drsc_host_model.sv
// serial host model issuing 24-bit mode 0 frames
// assumes sdo_line is already resolved with its pull-up
`timescale 1ns/100ps
`default_nettype none
module drsc_host_model #(
	parameter int half = 4
) (
	input wire logic clk,
	input wire logic sdo_line,
	output logic sclk,
	output logic sdi,
	output logic cs_n
);
	initial begin
		sclk = 1'b0;
		sdi = 1'b0;
		cs_n = 1'b1;
	end
	// sclk stands low between frames; call only just after a falling clk edge
	task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
		cs_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdi = tx[i];
			repeat (half) @(negedge clk);
			sclk = 1'b1;
			repeat (half) @(negedge clk);
			rx[i] = sdo_line;
			sclk = 1'b0;
		end
		repeat (half) @(negedge clk);
		cs_n = 1'b1;
		sdi = ~sdi;
		repeat (12) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking bench for the rheostat serial command unit
// assumes drsc_unit and drsc_host_model are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
	$display("ERROR %0t: value mismatch", $time); end end
module tb;
	logic clk;
	logic rst_n;
	logic wp_n;
	logic recall_strobe_n;
	logic sclk;
	logic sdi;
	logic cs_n;
	logic sdo_o;
	logic sdo_oe;
	logic read_power;
	logic [1023:0] tap1;
	logic [1023:0] tap2;
	logic [23:0] rx;
	int n_fail;
	int samples_checked;
	wire logic sdo_line = sdo_oe ? sdo_o : 1'b1;
	drsc_unit dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .sclk(sclk), .sdi(sdi), .cs_n(cs_n),
		.wp_n(wp_n), .recall_strobe_n(recall_strobe_n), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
		.tap_sel_ch1(tap1), .tap_sel_ch2(tap2), .read_power(read_power));
	drsc_host_model host (.clk(clk), .sdo_line(sdo_line), .sclk(sclk), .sdi(sdi), .cs_n(cs_n));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic fr(input logic [23:0] tx);
		host.xfer(tx, rx);
	endtask
	task automatic tv(input logic [9:0] a, input logic [9:0] b);
		`CHK(tap1, 1024'h1 << a)
		`CHK(tap2, 1024'h1 << b)
	endtask
	task automatic t_write;
		fr(24'hb00100);
		fr(24'hb10200);
		tv(10'h100, 10'h200);
		fr(24'he0ffff);
		`CHK(rx, 24'hb10200)
		fr(24'he01234);
		tv(10'h102, 10'h200);
		`CHK(rx, 24'he0ffff)
		fr(24'hb00000);
		tv(10'h000, 10'h200);
	endtask
	task automatic t_shift;
		fr(24'hb00200);
		fr(24'hb10005);
		fr(24'hc00000);
		fr(24'hc10000);
		tv(10'h3ff, 10'h00a);
		fr(24'ha00000);
		`CHK(read_power, 1'b1)
		fr(24'h000000);
		`CHK(rx, 24'ha003ff)
		`CHK(read_power, 1'b0)
		tv(10'h3ff, 10'h00a);
	endtask
	task automatic t_nv;
		fr(24'hb00123);
		fr(24'h200000);
		fr(24'h210000);
		fr(24'hb003ff);
		fr(24'h100000);
		tv(10'h123, 10'h00a);
		fr(24'hb10077);
		fr(24'h110000);
		tv(10'h123, 10'h00a);
		wp_n = 1'b0;
		fr(24'hb00055);
		fr(24'h200000);
		fr(24'hb10300);
		fr(24'h8fffff);
		tv(10'h123, 10'h00a);
		wp_n = 1'b1;
		fr(24'hb00001);
		recall_strobe_n = 1'b0;
		repeat (4) @(negedge clk);
		recall_strobe_n = 1'b1;
		repeat (8) @(negedge clk);
		tv(10'h123, 10'h00a);
		fr(24'hb00002);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (8) @(negedge clk);
		tv(10'h123, 10'h00a);
	endtask
	task automatic t_user;
		fr(24'h32aaaa);
		fr(24'h92ffff);
		fr(24'h000000);
		`CHK(rx, 24'h92aaaa)
		wp_n = 1'b0;
		fr(24'h325555);
		fr(24'h920000);
		fr(24'h000000);
		`CHK(rx, 24'h92aaaa)
		wp_n = 1'b1;
	endtask
	task automatic give_verdict;
		$display("checked %0d, failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		wp_n = 1'b1;
		recall_strobe_n = 1'b1;
		n_fail = 0;
		samples_checked = 0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (8) @(negedge clk);
		t_write();
		t_shift();
		t_nv();
		t_user();
		give_verdict();
	end
	// about 30 frames of 208 cycles each fit well inside this span
	initial begin
		#3ms;
		n_fail++;
		give_verdict();
	end
endmodule
`default_nettype wire
